// ==== rtl/uart9_pkg.sv ====
// Shared constants and state types for the nine-bit serial port
package uart9_pkg;

	localparam int DATA_W = 8;
	localparam int WORD_W = 9;
	localparam int BUF_DEPTH = 2;
	localparam int PRE_W = 2;
	localparam int CNT_W = 4;
	localparam int BIT_W = 4;

	// Sixteen samples per bit period
	localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
	localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;
	// Three middle samples; vote decided on the last
	localparam logic [CNT_W-1:0] SAMP_A = 4'h7;
	localparam logic [CNT_W-1:0] SAMP_B = 4'h8;
	localparam logic [CNT_W-1:0] SAMP_C = 4'h9;

	// Core clock /2 or /4, then /16: one tick every 2 or 4 clocks
	localparam logic [PRE_W-1:0] PRE_RST = 2'h0;
	localparam logic [PRE_W-1:0] PRE_SLOW_LAST = 2'h3;

	// Eleven-bit frame: start, 8 data, ninth, stop
	localparam logic [BIT_W-1:0] TX_SHIFT_BITS = 4'ha;
	localparam logic [BIT_W-1:0] RX_STOP_IDX = 4'ha;
	localparam logic [BIT_W-1:0] RX_START_IDX = 4'h0;
	localparam logic [BIT_W-1:0] BIT_ONE = 4'h1;
	localparam logic [BIT_W-1:0] BIT_ZERO = 4'h0;

	localparam logic [DATA_W-1:0] BUF_RST = 8'h00;
	localparam logic [2:0] VOTE_RST = 3'h0;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_BIT = 2'b10
	} rx_state_t;

endpackage

// ==== rtl/tx_word_buffer.sv ====
// Two-entry word buffer between the write port and the transmitter
`timescale 1ns/10ps
module tx_word_buffer #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	// Room kept as a flop so the ready port needs no gate
	logic room_reg;
	logic empty_reg;
	logic push;
	logic pop;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_LAST) ? '0 : p + 1'b1;
	endfunction

	assign push = in_valid && room_reg;
	assign pop = out_ready && !empty_reg;
	assign in_ready = room_reg;
	assign out_valid = !empty_reg;
	assign out_data = mem_reg[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			room_reg <= 1'b1;
			empty_reg <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			end
			count_reg <= count_next;
			room_reg <= (count_next != CNT_FULL);
			empty_reg <= (count_next == '0);
		end
	end

endmodule

// ==== rtl/uart_nine_bit_multiproc.sv ====
// Nine-bit serial port with multiprocessor address filter
// Function
// - Sending starts at first divide-by-16 rollover after a buffer write.
// - Shift out start, eight data bits LSB first, ninth bit, stop.
// - Transmit-done flag sets when the stop bit goes onto the pin.
// - Reception starts on a falling input edge, only while permitted.
// - Input pin sampled sixteen times per bit at any rate.
// - Start edge resets the receive divide-by-16 counter to align bits.
// - Each bit decided by majority of three middle samples.
// - Start bit not voted low abandons frame; wait for new edge.
// - Mid stop: accept if receive-done clear and, if filtering, stop 1 and ninth bit 1.
// - Accepted frame loads buffer, ninth bit flag, and sets receive-done.
// - Rejected frame leaves buffer, ninth bit and receive-done unchanged.
// - After mid stop bit return to idle awaiting next falling edge.
// - Mode 3 uses same frame, bit rate from timer overflows.
// - Every character is eleven bits: start, eight data, ninth, stop.
// - Filtering active in modes 2 and 3 only when filter bit set.
// - With filtering, receive event only when received ninth bit is 1.
// - No address comparison in hardware; software decides if addressed.
// - Mode 2 bit rate is clock/64, or clock/32 with baud doubler.
// - Transmitted ninth bit comes from the transmit ninth bit control.
// - Timer overflows clock the baud circuit, divided by 32 per bit, or 16 with baud doubler.
`timescale 1ns/10ps
module uart_nine_bit_multiproc
	import uart9_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic mode3_sel,
	input wire logic baud_doubler,
	input wire logic timer_ovf,
	input wire logic rx_enable,
	input wire logic addr_filter_bit,
	input wire logic tx_ninth_bit,
	input wire logic wr_valid,
	input wire logic [DATA_W-1:0] wr_data,
	output logic wr_ready,
	input wire logic tx_done_clr,
	input wire logic rx_done_clr,
	input wire logic rxd,
	output logic txd,
	output logic [DATA_W-1:0] serial_buffer,
	output logic rx_ninth_bit,
	output logic tx_done_flag,
	output logic rx_done_flag,
	output logic serial_irq
);

	logic [PRE_W-1:0] pre_reg;
	logic ovf_half_reg;
	logic tick;

	logic buf_valid;
	logic [WORD_W-1:0] buf_data;
	logic buf_pop;

	tx_state_t tx_state_reg;
	logic [CNT_W-1:0] tx_cnt_reg;
	logic [BIT_W-1:0] tx_bits_reg;
	logic [WORD_W:0] tx_shift_reg;
	logic txd_reg;
	logic tx_roll;
	logic tx_start;
	logic tx_set;

	rx_state_t rx_state_reg;
	logic [CNT_W-1:0] rx_cnt_reg;
	logic [BIT_W-1:0] rx_idx_reg;
	logic [WORD_W-1:0] rx_shift_reg;
	logic [2:0] vote_reg;
	logic samp_prev_reg;
	logic rx_fall;
	logic rx_decide;
	logic bit_val;
	logic rx_end;
	logic rx_accept;
	logic start_fail;

	logic [DATA_W-1:0] rx_byte_reg;
	logic rx_ninth_reg;
	logic tx_flag_reg;
	logic rx_flag_reg;
	logic irq_reg;

	function automatic logic majority(input logic [2:0] v);
		majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Baud tick at sixteen times the bit rate
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pre_reg <= PRE_RST;
		end else if (mode3_sel) begin
			pre_reg <= PRE_RST;
		end else begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	// Without the doubler every other overflow is dropped
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ovf_half_reg <= 1'b0;
		end else if (timer_ovf) begin
			ovf_half_reg <= !ovf_half_reg;
		end
	end

	always_comb begin
		if (mode3_sel) begin
			tick = timer_ovf && (baud_doubler || ovf_half_reg);
		end else if (baud_doubler) begin
			tick = pre_reg[0];
		end else begin
			tick = (pre_reg == PRE_SLOW_LAST);
		end
	end

	// Ninth bit captured with the byte so a later change cannot tear it
	tx_word_buffer #(
		.WIDTH(WORD_W),
		.DEPTH(BUF_DEPTH)
	) tx_word_buffer_inst (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(wr_valid),
		.in_data({tx_ninth_bit, wr_data}),
		.in_ready(wr_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(buf_pop)
	);

	// Transmit divide-by-16 runs freely
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_cnt_reg <= CNT_RST;
		end else if (tick) begin
			tx_cnt_reg <= tx_cnt_reg + 1'b1;
		end
	end

	assign tx_roll = tick && (tx_cnt_reg == CNT_LAST);
	assign tx_start = tx_roll && buf_valid && (tx_state_reg == TX_IDLE ||
		tx_bits_reg == BIT_ZERO);
	assign tx_set = tx_roll && tx_state_reg == TX_SEND &&
		tx_bits_reg == BIT_ONE;
	assign buf_pop = tx_start;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_state_reg <= TX_IDLE;
			tx_bits_reg <= BIT_ZERO;
			tx_shift_reg <= '1;
			txd_reg <= 1'b1;
		end else if (tx_start) begin
			tx_state_reg <= TX_SEND;
			txd_reg <= 1'b0;
			tx_shift_reg <= {1'b1, buf_data};
			tx_bits_reg <= TX_SHIFT_BITS;
		end else if (tx_roll) begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					txd_reg <= 1'b1;
				end
				TX_SEND: begin
					if (tx_bits_reg == BIT_ZERO) begin
						tx_state_reg <= TX_IDLE;
					end else begin
						txd_reg <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[WORD_W:1]};
						tx_bits_reg <= tx_bits_reg - 1'b1;
					end
				end
				default: begin
					tx_state_reg <= TX_IDLE;
				end
			endcase
		end
	end

	// Receive samples are taken on the tick only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			samp_prev_reg <= 1'b1;
		end else if (tick) begin
			samp_prev_reg <= rxd;
		end
	end

	assign rx_fall = tick && rx_enable && samp_prev_reg && !rxd &&
		rx_state_reg == RX_IDLE;
	assign rx_decide = tick && rx_state_reg == RX_BIT &&
		rx_cnt_reg == SAMP_C;
	assign bit_val = majority({vote_reg[1:0], rxd});
	assign start_fail = rx_decide && rx_idx_reg == RX_START_IDX &&
		bit_val;
	assign rx_end = rx_decide && rx_idx_reg == RX_STOP_IDX;
	// Stop and ninth bit both checked when filtering
	assign rx_accept = rx_end && !rx_flag_reg && (!addr_filter_bit ||
		(bit_val && rx_shift_reg[WORD_W-1]));

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			vote_reg <= VOTE_RST;
		end else if (tick && (rx_cnt_reg == SAMP_A || rx_cnt_reg == SAMP_B)) begin
			vote_reg <= {vote_reg[1:0], rxd};
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg <= CNT_RST;
			rx_idx_reg <= BIT_ZERO;
			rx_shift_reg <= '0;
		end else if (rx_fall) begin
			rx_state_reg <= RX_BIT;
			rx_cnt_reg <= CNT_RST + 1'b1;
			rx_idx_reg <= RX_START_IDX;
		end else if (start_fail || rx_end) begin
			rx_state_reg <= RX_IDLE;
		end else if (tick && rx_state_reg == RX_BIT) begin
			rx_cnt_reg <= rx_cnt_reg + 1'b1;
			if (rx_decide) begin
				rx_shift_reg <= {bit_val, rx_shift_reg[WORD_W-1:1]};
			end
			if (rx_cnt_reg == CNT_LAST) begin
				rx_idx_reg <= rx_idx_reg + 1'b1;
			end
		end
	end

	// Address bytes are delivered as-is; software compares them
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_byte_reg <= BUF_RST;
			rx_ninth_reg <= 1'b0;
		end else if (rx_accept) begin
			rx_byte_reg <= rx_shift_reg[DATA_W-1:0];
			rx_ninth_reg <= rx_shift_reg[WORD_W-1];
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_flag_reg <= 1'b0;
			rx_flag_reg <= 1'b0;
		end else begin
			tx_flag_reg <= tx_set || (tx_flag_reg && !tx_done_clr);
			rx_flag_reg <= rx_accept || (rx_flag_reg && !rx_done_clr);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= tx_flag_reg || rx_flag_reg;
		end
	end

	assign txd = txd_reg;
	assign serial_buffer = rx_byte_reg;
	assign rx_ninth_bit = rx_ninth_reg;
	assign tx_done_flag = tx_flag_reg;
	assign rx_done_flag = rx_flag_reg;
	assign serial_irq = irq_reg;

	property p_txf_hold;
		@(posedge mclk) disable iff (sys_rst)
		tx_done_flag && !tx_done_clr && !tx_set |=> tx_done_flag;
	endproperty
	a_txf_hold: assert property (p_txf_hold)
		else $error("tx done lost");

	property p_txf_stop;
		@(posedge mclk) disable iff (sys_rst)
		tx_set |=> txd && tx_done_flag;
	endproperty
	a_txf_stop: assert property (p_txf_stop)
		else $error("tx done not at stop");

	property p_tx_start_low;
		@(posedge mclk) disable iff (sys_rst)
		tx_start |=> !txd ##1 !txd[*1];
	endproperty
	a_tx_start_low: assert property (p_tx_start_low)
		else $error("no start bit");

	property p_rx_reject;
		@(posedge mclk) disable iff (sys_rst)
		rx_end && !rx_accept |=> $stable(serial_buffer) && $stable(rx_ninth_bit);
	endproperty
	a_rx_reject: assert property (p_rx_reject)
		else $error("reject loaded");

	property p_rx_load;
		@(posedge mclk) disable iff (sys_rst)
		rx_accept |=> rx_done_flag &&
			{rx_ninth_bit, serial_buffer} == $past(rx_shift_reg);
	endproperty
	a_rx_load: assert property (p_rx_load)
		else $error("accept not loaded");

	property p_rx_gate;
		@(posedge mclk) disable iff (sys_rst)
		rx_state_reg == RX_IDLE && !rx_enable |=> rx_state_reg == RX_IDLE;
	endproperty
	a_rx_gate: assert property (p_rx_gate)
		else $error("rx started");

	property p_false_start;
		@(posedge mclk) disable iff (sys_rst)
		start_fail |=> rx_state_reg == RX_IDLE && !$rose(rx_done_flag);
	endproperty
	a_false_start: assert property (p_false_start)
		else $error("bad start");

	property p_filter;
		@(posedge mclk) disable iff (sys_rst)
		rx_accept && addr_filter_bit |=> rx_ninth_bit;
	endproperty
	a_filter: assert property (p_filter)
		else $error("data byte passed");

	// A mode switch may legally bring a tick right after another
	property p_tick2;
		@(posedge mclk) disable iff (sys_rst)
		!mode3_sel && tick ##1 !mode3_sel |-> !tick;
	endproperty
	a_tick2: assert property (p_tick2)
		else $error("tick too fast");

	property p_rx_align;
		@(posedge mclk) disable iff (sys_rst)
		rx_fall |=> rx_state_reg == RX_BIT && rx_cnt_reg == CNT_RST + 1'b1;
	endproperty
	a_rx_align: assert property (p_rx_align)
		else $error("rx count not aligned");

	property p_data_quiet;
		@(posedge mclk) disable iff (sys_rst)
		rx_end && addr_filter_bit && !rx_shift_reg[WORD_W-1] |=>
			!$rose(rx_done_flag);
	endproperty
	a_data_quiet: assert property (p_data_quiet)
		else $error("data byte raised event");

	c_accept: cover property (@(posedge mclk) rx_accept);
	c_filtered: cover property (@(posedge mclk) rx_end && !rx_accept);
	c_tx_done: cover property (@(posedge mclk) tx_set);
	c_false: cover property (@(posedge mclk) start_fail);
	c_full: cover property (@(posedge mclk) wr_valid && !wr_ready);

endmodule

// ==== bench/remote_uart.sv ====
// Far-end serial partner: frame sender and frame receiver
`timescale 1ns/10ps
module remote_uart (
	input wire logic mclk,
	input wire logic txd,
	output logic rxd
);
	initial rxd = 1'b1;

	// Bits change on the falling edge; idle line is high
	task automatic send(input logic [7:0] d, input logic n,
		input logic stp, input int bp);
		logic [10:0] f;
		f = {stp, n, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(negedge mclk);
			rxd = f[i];
			repeat (bp - 1) @(negedge mclk);
		end
		@(negedge mclk);
		rxd = 1'b1;
	endtask

	// Short low pulse, too brief to pass the start vote
	task automatic glitch(input int n);
		@(negedge mclk);
		rxd = 1'b0;
		repeat (n) @(negedge mclk);
		rxd = 1'b1;
	endtask

	// Mid-bit sampling; w counts clocks spent waiting for start
	task automatic recv(input int bp, output logic [10:0] f,
		output int w);
		w = 0;
		while (txd !== 1'b0 && w < 4000) begin
			@(posedge mclk);
			w++;
		end
		repeat (bp / 2) @(posedge mclk);
		for (int i = 0; i < 11; i++) begin
			f[i] = txd;
			if (i < 10) repeat (bp) @(posedge mclk);
		end
	endtask
endmodule

// ==== bench/uart_nine_bit_multiproc_tb_top.sv ====
// Bench for the nine-bit serial port
`timescale 1ns/10ps
module uart_nine_bit_multiproc_tb_top;
	import uart9_pkg::*;
	typedef struct packed {
		logic m3, dbl, filt, ren;
		logic [7:0] d;
		logic n, stp, acc;
	} row_t;
	// Set at declaration so no edge is seen at time zero
	logic mclk = 1'b0;
	logic sys_rst, mode3_sel, baud_doubler, timer_ovf;
	logic rx_enable, addr_filter_bit, tx_ninth_bit, wr_valid;
	logic tx_done_clr, rx_done_clr, wr_ready, txd, rxd;
	logic rx_ninth_bit, tx_done_flag, rx_done_flag, serial_irq;
	logic [7:0] wr_data, serial_buffer;
	logic [1:0] ovf_cnt = 2'h0;
	logic [10:0] f;
	logic [8:0] prev;
	int miscompares, total_checks, cycles, w, ws, bp;
	row_t r;
	// Addresses carry ninth bit 1, data bytes ninth bit 0
	row_t rows [7] = '{{4'h1, 8'ha5, 3'h7}, {4'h5, 8'h3c, 3'h3},
		{4'hd, 8'h81, 3'h5}, {4'hb, 8'h5a, 3'h7}, {4'h7, 8'h66, 3'h2},
		{4'hf, 8'h99, 3'h4}, {4'h4, 8'h12, 3'h6}};

	uart_nine_bit_multiproc uart_nine_bit_multiproc_inst (
		.mclk(mclk), .sys_rst(sys_rst), .mode3_sel(mode3_sel),
		.baud_doubler(baud_doubler), .timer_ovf(timer_ovf),
		.rx_enable(rx_enable), .addr_filter_bit(addr_filter_bit),
		.tx_ninth_bit(tx_ninth_bit), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_ready(wr_ready),
		.tx_done_clr(tx_done_clr), .rx_done_clr(rx_done_clr),
		.rxd(rxd), .txd(txd), .serial_buffer(serial_buffer),
		.rx_ninth_bit(rx_ninth_bit), .tx_done_flag(tx_done_flag),
		.rx_done_flag(rx_done_flag), .serial_irq(serial_irq));
	remote_uart remote_uart_inst (.mclk(mclk), .txd(txd), .rxd(rxd));

	always #4 mclk = ~mclk;
	// Overflow every third clock keeps mode 3 runs short
	always @(negedge mclk) begin
		ovf_cnt <= (ovf_cnt == 2'h2) ? 2'h0 : ovf_cnt + 2'h1;
		timer_ovf <= (ovf_cnt == 2'h2);
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			print_verdict();
		end
	end

	function automatic int bp_of(logic m3, logic dbl);
		return m3 ? (dbl ? 48 : 96) : (dbl ? 32 : 64);
	endfunction
	task automatic cmp_bit(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_word(input logic [10:0] g, input logic [10:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Holds the request until accepted; w counts refused cycles
	task automatic put_word(input logic [7:0] d, input logic n,
		inout int w);
		@(negedge mclk);
		wr_data = d;
		tx_ninth_bit = n;
		wr_valid = 1'b1;
		@(posedge mclk);
		while (wr_ready !== 1'b1) begin
			w++;
			@(posedge mclk);
		end
		@(negedge mclk);
		wr_valid = 1'b0;
	endtask
	task automatic clr(input logic t, input logic x);
		@(negedge mclk);
		tx_done_clr = t;
		rx_done_clr = x;
		@(negedge mclk);
		tx_done_clr = 1'b0;
		rx_done_clr = 1'b0;
		@(negedge mclk);
	endtask
	task automatic cfg(input row_t c);
		@(negedge mclk);
		{mode3_sel, baud_doubler, addr_filter_bit, rx_enable} = c[14:11];
		bp = bp_of(c.m3, c.dbl);
	endtask

	initial begin
		sys_rst = 1'b1;
		{mode3_sel, baud_doubler, timer_ovf, rx_enable} = 4'h0;
		{addr_filter_bit, tx_ninth_bit, wr_valid} = 3'h0;
		{tx_done_clr, rx_done_clr} = 2'h0;
		wr_data = 8'h00;
		repeat (4) @(negedge mclk);
		cmp_word({txd, wr_ready, tx_done_flag, rx_done_flag, serial_irq,
			rx_ninth_bit, 5'h00}, 11'h600);
		cmp_word({3'h0, serial_buffer}, 11'h000);
		$display("reset test done");
		sys_rst = 1'b0;
		foreach (rows[i]) begin
			r = rows[i];
			cfg(r);
			ws = 0;
			fork
				put_word(r.d, r.n, ws);
				remote_uart_inst.recv(bp, f, w);
			join
			cmp_word(f, {1'b1, r.n, r.d, 1'b0});
			cmp_bit(w <= bp + 4, 1'b1);
			cmp_bit(tx_done_flag, 1'b1);
			prev = {rx_ninth_bit, serial_buffer};
			remote_uart_inst.send(r.d, r.n, r.stp, bp);
			repeat (2) @(negedge mclk);
			cmp_bit(rx_done_flag, r.acc);
			cmp_word({2'h0, rx_ninth_bit, serial_buffer},
				r.acc ? {2'h0, r.n, r.d} : {2'h0, prev});
			cmp_bit(tx_done_flag, 1'b1);
			clr(1'b1, 1'b1);
			cmp_bit(serial_irq, 1'b0);
			$display("row %0d done", i);
		end
		cfg({4'h5, 8'h00, 3'h0});
		remote_uart_inst.glitch(4);
		repeat (64) @(negedge mclk);
		cmp_bit(rx_done_flag, 1'b0);
		remote_uart_inst.send(8'hc3, 1'b1, 1'b1, bp);
		repeat (2) @(negedge mclk);
		cmp_word({2'h0, rx_ninth_bit, serial_buffer}, 11'h1c3);
		cmp_bit(serial_irq, 1'b1);
		$display("false start test done");
		remote_uart_inst.send(8'h3e, 1'b0, 1'b1, bp);
		repeat (2) @(negedge mclk);
		cmp_word({2'h0, rx_ninth_bit, serial_buffer}, 11'h1c3);
		cmp_bit(rx_done_flag, 1'b1);
		clr(1'b0, 1'b1);
		$display("overrun test done");
		ws = 0;
		fork
			for (int k = 1; k < 5; k++)
				put_word(8'(k * 17), k[0], ws);
			for (int k = 1; k < 5; k++) begin
				remote_uart_inst.recv(bp, f, w);
				cmp_word(f, {1'b1, k[0], 8'(k * 17), 1'b0});
				if (k > 1) cmp_bit(w <= bp / 2 + 2, 1'b1);
			end
		join
		cmp_bit(ws > 0, 1'b1);
		$display("back to back test done");
		print_verdict();
	end
endmodule
